// *** sep_pkg.sv ***
/*
  Shared constants and types of the serial EEPROM command engine.
  Assumes a single core clock of 40 MHz and pins sampled into that clock.
*/
package sep_pkg;

  // Core clock and derived time base
  localparam int CLK_PERIOD_NS = 25;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYC = TICK_NS / CLK_PERIOD_NS;
  localparam int TICK_W = 6;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYC - 1);

  // Self-timed program cycle, in microseconds
  localparam int PROG_TIME_US = 5000;
  localparam int PROG_CNT_W = 16;

  // Byte framing on the serial link
  localparam int SYNC_LEN = 3;
  localparam logic [3:0] BIT_LAST_DATA = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_DONE = 4'h9;

  // Array and page
  localparam int PAGE_BYTES = 16;
  localparam int PAGE_BITS = 4;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam int FIFO_DEPTH = 4;

  // Pin bundle: serial clock, serial data, guard, straps
  localparam int PIN_W = 6;
  localparam logic [PIN_W-1:0] PINS_RST = 6'h30;

  typedef struct packed {
    logic scl;
    logic sda;
    logic guard;
    logic [2:0] straps;
  } sep_pins_t;

  // Gray codes along select -> address -> data -> program
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_SEL = 3'h1,
    ST_ADR = 3'h3,
    ST_WDAT = 3'h2,
    ST_PROG = 3'h6,
    ST_TXD = 3'h5
  } sep_state_t;

  typedef struct packed {
    logic [PAGE_BYTES-1:0] mask;
    logic [PAGE_BYTES-1:0][7:0] data;
  } sep_page_t;

endpackage : sep_pkg

// *** sep_fifo.sv ***
/*
  Small flip-flop FIFO with valid/ready on both sides and a flush.
  Assumes both sides run on core_clk; flush wins over a push or pop.
*/
`timescale 1ns/1ps
module sep_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 4
) (
  input logic core_clk,
  input logic rst,
  input logic flush,
  input logic in_valid,
  output logic in_ready,
  input logic [W-1:0] in_data,
  output logic out_valid,
  input logic out_ready,
  output logic [W-1:0] out_data
);

  localparam int PW = $clog2(DEPTH);

  logic [W-1:0] slot_r [DEPTH];
  logic [W-1:0] slot_nxt [DEPTH];
  logic [PW:0] wr_r;
  logic [PW:0] wr_nxt;
  logic [PW:0] rd_r;
  logic [PW:0] rd_nxt;
  logic full;
  logic empty;

  // Extra pointer bit tells full from empty
  assign full = (wr_r[PW] != rd_r[PW]) && (wr_r[PW-1:0] == rd_r[PW-1:0]);
  assign empty = (wr_r == rd_r);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = slot_r[rd_r[PW-1:0]];

  // Pointer and slot update
  always_comb
  begin
    slot_nxt = slot_r;
    wr_nxt = wr_r;
    rd_nxt = rd_r;
    if (flush)
    begin
      wr_nxt = '0;
      rd_nxt = '0;
    end
    else
    begin
      if (in_valid && !full)
      begin
        slot_nxt[wr_r[PW-1:0]] = in_data;
        wr_nxt = wr_r + 1'b1;
      end
      if (out_ready && !empty)
        rd_nxt = rd_r + 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < DEPTH; i++)
        slot_r[i] <= '0;
      wr_r <= '0;
      rd_r <= '0;
    end
    else
    begin
      slot_r <= slot_nxt;
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
    end
  end

endmodule : sep_fifo

// *** sep_array.sv ***
/*
  Byte array in flip-flops, erased to all ones at reset, with one
  combinational read port and a whole-page masked commit.
  Assumes commit is a one-cycle pulse with page index and data stable.
*/
`timescale 1ns/1ps
module sep_array #(
  parameter int AW = 8
) (
  input logic core_clk,
  input logic rst,
  input logic [AW-1:0] rd_addr,
  output logic [7:0] rd_data,
  input logic commit,
  input logic [AW-sep_pkg::PAGE_BITS-1:0] page_idx,
  input sep_pkg::sep_page_t page
);

  localparam int N = 2 ** AW;

  logic [7:0] cell_r [N];
  logic [7:0] cell_nxt [N];

  assign rd_data = cell_r[rd_addr];

  // One cell per entry; only masked bytes of the addressed page change
  for (genvar g = 0; g < N; g++)
  begin : g_cell
    localparam logic [AW-1:0] IDX = AW'(g);
    always_comb
    begin
      cell_nxt[g] = cell_r[g];
      if (commit && page_idx == IDX[AW-1:sep_pkg::PAGE_BITS] &&
          page.mask[IDX[sep_pkg::PAGE_BITS-1:0]])
        cell_nxt[g] = page.data[IDX[sep_pkg::PAGE_BITS-1:0]];
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
      if (rst)
        cell_r[g] <= sep_pkg::ERASED_BYTE;
      else
        cell_r[g] <= cell_nxt[g];
    end
  end

endmodule : sep_array

// *** sep_core.sv ***
/*
  Command engine of a byte-organised serial EEPROM acting as a two-wire
  bus slave: select, address, page write with timed program cycle,
  acknowledge polling, and current, random and sequential reads.
  Assumes the serial clock and data pins are asynchronous to core_clk and
  far slower than it; the data pin is open drain with an external pull-up.
*/
`timescale 1ns/1ps
// Function
// - Write select is acknowledged, then address byte acked, then data
// - Program cycle starts only on Stop right after a data acknowledge
// - Stop in any other slot starts no program cycle
// - After programming, counter points past the last modified byte
// - During programming, data line released and bus fully ignored
// - Guard high: data bytes get NoAck and nothing is written
// - Page write takes one to sixteen bytes within one page
// - Page write increments only the low four address bits
// - Select code gets no acknowledge while programming, acked afterwards
// - Reads behave the same at any guard level
// - Random read: dummy write address, repeated Start, read select
// - Current read: ack, send byte at counter, then increment
// - Master acknowledge makes the device send the next byte
// - Counter wraps from top address to zero during reads
// - Read acknowledge slot high ends transfer and returns to standby
// - Array starts with every byte all ones
// - Select needs type identifier and matching straps or address bits
// - Select bit zero picks read at one, write at zero
// - Matching select acked in ninth slot; mismatch returns to standby
// - Guard high still acknowledges select and address bytes
module sep_core #(
  parameter int AW = 8,
  parameter int PROG_US = sep_pkg::PROG_TIME_US,
  parameter logic [3:0] TYPE_ID = 4'h9 // Arbitrary value
) (
  input logic core_clk,
  input logic rst,
  input logic scl_i,
  input logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  input logic write_guard_input,
  input logic [2:0] chip_select_straps,
  output logic prog_busy
);

  localparam int XA = AW - 8;
  localparam int PROG_TICKS = PROG_US * 1000 / sep_pkg::TICK_NS;
  localparam logic [sep_pkg::PROG_CNT_W-1:0] PROG_LAST =
    sep_pkg::PROG_CNT_W'(PROG_TICKS - 1);

  sep_pkg::sep_pins_t sync_r [sep_pkg::SYNC_LEN];
  logic [sep_pkg::PIN_W-1:0] filt_nxt;
  sep_pkg::sep_pins_t pin_f;
  sep_pkg::sep_pins_t pin_p;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;

  sep_pkg::sep_state_t state_r, state_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic [7:0] shift_r, shift_nxt;
  logic [7:0] tx_r, tx_nxt;
  logic ack_r, ack_nxt;
  logic drive_r, drive_nxt;
  logic rw_r, rw_nxt;
  logic [2:0] sel_r, sel_nxt;
  logic [AW-1:0] addr_r, addr_nxt;
  logic [AW-1:0] last_r, last_nxt;
  logic flush_r, flush_nxt;
  sep_pkg::sep_page_t page_r, page_nxt;
  logic [7:0] byte_in;
  logic [10:0] full_addr;
  logic sel_ok;
  logic load;

  logic [sep_pkg::TICK_W-1:0] tick_r, tick_nxt;
  logic [sep_pkg::PROG_CNT_W-1:0] prog_cnt_r, prog_cnt_nxt;
  logic commit;

  logic [AW-1:0] fetch_r, fetch_nxt;
  logic [7:0] mem_data;
  logic fifo_in_ready;
  logic [7:0] fifo_data;
  logic pop;

  // Pins pass three flops; a level counts once stages two and three agree
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < sep_pkg::SYNC_LEN; i++)
        sync_r[i] <= sep_pkg::PINS_RST;
      pin_f <= sep_pkg::PINS_RST;
      pin_p <= sep_pkg::PINS_RST;
    end
    else
    begin
      sync_r[0] <= {scl_i, sda_i, write_guard_input, chip_select_straps};
      sync_r[1] <= sync_r[0];
      sync_r[2] <= sync_r[1];
      pin_f <= filt_nxt;
      pin_p <= pin_f;
    end
  end

  for (genvar g = 0; g < sep_pkg::PIN_W; g++)
  begin : g_filt
    always_comb
      filt_nxt[g] = (sync_r[1][g] == sync_r[2][g]) ? sync_r[2][g] : pin_f[g];
  end

  // Bus events from the filtered levels
  assign scl_rise = pin_f.scl && !pin_p.scl;
  assign scl_fall = !pin_f.scl && pin_p.scl;
  assign start_ev = pin_f.scl && pin_p.scl && pin_p.sda && !pin_f.sda;
  assign stop_ev = pin_f.scl && pin_p.scl && !pin_p.sda && pin_f.sda;

  // Open drain: only ever pulls low
  assign sda_o = 1'b0;
  assign sda_oe_n = !drive_r;
  assign prog_busy = (state_r == sep_pkg::ST_PROG);

  // Byte completes on the eighth rising edge
  assign byte_in = {shift_r[6:0], pin_f.sda};
  assign full_addr = {sel_r, byte_in};

  // Select decode: type nibble, then straps on bits not used as address
  always_comb
  begin
    sel_ok = (byte_in[7:4] == TYPE_ID);
    for (int i = 0; i < 3; i++)
      if (i >= XA && byte_in[i+1] != pin_f.straps[i])
        sel_ok = 1'b0;
  end

  // Protocol engine
  always_comb
  begin
    state_nxt = state_r;
    bit_nxt = bit_r;
    shift_nxt = shift_r;
    tx_nxt = tx_r;
    ack_nxt = ack_r;
    drive_nxt = drive_r;
    rw_nxt = rw_r;
    sel_nxt = sel_r;
    addr_nxt = addr_r;
    last_nxt = last_r;
    page_nxt = page_r;
    flush_nxt = 1'b0;
    load = 1'b0;
    if (state_r == sep_pkg::ST_PROG)
    begin
      // Deaf to the bus until the timer ends, so polls see no ack
      drive_nxt = 1'b0;
      if (commit)
      begin
        state_nxt = sep_pkg::ST_IDLE;
        addr_nxt = AW'(last_r + 1'b1);
        page_nxt.mask = '0;
      end
    end
    else if (start_ev)
    begin
      // Also a repeated start: any unfinished page is dropped
      state_nxt = sep_pkg::ST_SEL;
      bit_nxt = '0;
      drive_nxt = 1'b0;
      page_nxt.mask = '0;
    end
    else if (stop_ev)
    begin
      drive_nxt = 1'b0;
      // The SCL rise ahead of a Stop is sampled as one bit, so the slot
      // right after a data acknowledge shows up as bit count one
      if (state_r == sep_pkg::ST_WDAT && bit_r == 4'h1 && |page_r.mask)
        state_nxt = sep_pkg::ST_PROG;
      else
      begin
        state_nxt = sep_pkg::ST_IDLE;
        page_nxt.mask = '0;
      end
    end
    else if (scl_rise)
    begin
      unique case (state_r)
        sep_pkg::ST_SEL, sep_pkg::ST_ADR, sep_pkg::ST_WDAT:
        begin
          if (bit_r < sep_pkg::BIT_ACK)
          begin
            shift_nxt = byte_in;
            bit_nxt = bit_r + 4'h1;
          end
          else
            bit_nxt = sep_pkg::BIT_DONE;
          if (bit_r == sep_pkg::BIT_LAST_DATA)
          begin
            ack_nxt = 1'b1;
            if (state_r == sep_pkg::ST_SEL)
            begin
              if (!sel_ok)
                state_nxt = sep_pkg::ST_IDLE;
              rw_nxt = byte_in[0];
              sel_nxt = byte_in[3:1];
              flush_nxt = byte_in[0];
            end
            else if (state_r == sep_pkg::ST_ADR)
              addr_nxt = full_addr[AW-1:0];
            else if (pin_f.guard)
              ack_nxt = 1'b0;
            else
            begin
              page_nxt.data[addr_r[3:0]] = byte_in;
              page_nxt.mask[addr_r[3:0]] = 1'b1;
              last_nxt = addr_r;
              addr_nxt = {addr_r[AW-1:4], addr_r[3:0] + 4'h1};
            end
          end
        end
        sep_pkg::ST_TXD:
        begin
          if (bit_r < sep_pkg::BIT_ACK)
            bit_nxt = bit_r + 4'h1;
          else if (!pin_f.sda)
            bit_nxt = sep_pkg::BIT_DONE;
          else
            state_nxt = sep_pkg::ST_IDLE;
        end
        default:
          ;
      endcase
    end
    else if (scl_fall)
    begin
      unique case (state_r)
        sep_pkg::ST_SEL, sep_pkg::ST_ADR, sep_pkg::ST_WDAT:
        begin
          if (bit_r == sep_pkg::BIT_ACK)
            drive_nxt = ack_r;
          else if (bit_r == sep_pkg::BIT_DONE)
          begin
            drive_nxt = 1'b0;
            bit_nxt = '0;
            if (state_r == sep_pkg::ST_SEL && rw_r)
              load = 1'b1;
            else if (state_r == sep_pkg::ST_SEL)
              state_nxt = sep_pkg::ST_ADR;
            else
              state_nxt = sep_pkg::ST_WDAT;
          end
        end
        sep_pkg::ST_TXD:
        begin
          if (bit_r == sep_pkg::BIT_ACK)
            drive_nxt = 1'b0;
          else if (bit_r == sep_pkg::BIT_DONE)
          begin
            bit_nxt = '0;
            load = 1'b1;
          end
          else if (bit_r != '0)
          begin
            tx_nxt = {tx_r[6:0], 1'b0};
            drive_nxt = !tx_r[6];
          end
        end
        default:
          ;
      endcase
    end
    // Next byte to send comes from the prefetch queue; counter follows
    if (load)
    begin
      state_nxt = sep_pkg::ST_TXD;
      tx_nxt = fifo_data;
      drive_nxt = !fifo_data[7];
      addr_nxt = AW'(addr_r + 1'b1);
    end
  end

  assign pop = load;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state_r <= sep_pkg::ST_IDLE;
      bit_r <= '0;
      shift_r <= '0;
      tx_r <= '0;
      ack_r <= 1'b0;
      drive_r <= 1'b0;
      rw_r <= 1'b0;
      sel_r <= '0;
      addr_r <= '0;
      last_r <= '0;
      page_r <= '0;
      flush_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      bit_r <= bit_nxt;
      shift_r <= shift_nxt;
      tx_r <= tx_nxt;
      ack_r <= ack_nxt;
      drive_r <= drive_nxt;
      rw_r <= rw_nxt;
      sel_r <= sel_nxt;
      addr_r <= addr_nxt;
      last_r <= last_nxt;
      page_r <= page_nxt;
      flush_r <= flush_nxt;
    end
  end

  // Free-running microsecond tick; program time counts whole ticks, so
  // the cycle may run up to one tick short of the nominal figure
  always_comb
  begin
    tick_nxt = (tick_r == sep_pkg::TICK_LAST) ? '0 : tick_r + 1'b1;
    prog_cnt_nxt = prog_cnt_r;
    commit = 1'b0;
    if (state_r != sep_pkg::ST_PROG)
      prog_cnt_nxt = '0;
    else if (tick_r == sep_pkg::TICK_LAST)
    begin
      if (prog_cnt_r == PROG_LAST)
        commit = 1'b1;
      else
        prog_cnt_nxt = prog_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      tick_r <= '0;
      prog_cnt_r <= '0;
    end
    else
    begin
      tick_r <= tick_nxt;
      prog_cnt_r <= prog_cnt_nxt;
    end
  end

  // Prefetch runs ahead of the counter; a read select restarts it there
  always_comb
  begin
    fetch_nxt = fetch_r;
    if (flush_r)
      fetch_nxt = addr_r;
    else if (fifo_in_ready)
      fetch_nxt = AW'(fetch_r + 1'b1);
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      fetch_r <= '0;
    else
      fetch_r <= fetch_nxt;
  end

  sep_fifo #(
    .W(8),
    .DEPTH(sep_pkg::FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .rst(rst),
    .flush(flush_r),
    .in_valid(!flush_r),
    .in_ready(fifo_in_ready),
    .in_data(mem_data),
    .out_valid(),
    .out_ready(pop),
    .out_data(fifo_data)
  );

  sep_array #(
    .AW(AW)
  ) u_array (
    .core_clk(core_clk),
    .rst(rst),
    .rd_addr(fetch_r),
    .rd_data(mem_data),
    .commit(commit),
    .page_idx(last_r[AW-1:sep_pkg::PAGE_BITS]),
    .page(page_r)
  );

endmodule : sep_core

// *** sep_core_props.sv ***
/* Port checker of the EEPROM command engine, bound to sep_core.
   Assumes bus pins held at least 10 core clocks in each phase. */
`timescale 1ns/1ps
module sep_core_props #(
  parameter int PROG_US = 5000
) (
  input logic core_clk,
  input logic rst,
  input logic scl_i,
  input logic sda_i,
  input logic sda_o,
  input logic sda_oe_n,
  input logic write_guard_input,
  input logic [2:0] chip_select_straps,
  input logic prog_busy
);
  localparam int MAXC = PROG_US * sep_pkg::TICK_CYC;
  logic [31:0] busy_r;
  logic [31:0] busy_nxt;
  // Cycles spent in the current program cycle
  always_comb busy_nxt = prog_busy ? busy_r + 32'h1 : 32'h0;
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
      busy_r <= 32'h0;
    else
      busy_r <= busy_nxt;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (rst);
  // Open drain: the pin is only ever pulled low
  a_od_low: assert property (sda_o == 1'b0)
    else $error("sda_o not low");
  a_busy_quiet: assert property (prog_busy |-> sda_oe_n)
    else $error("line driven while programming");
  a_prog_stop: assert property ($rose(prog_busy) |-> scl_i && sda_i)
    else $error("program cycle without a stop");
  a_prog_hold: assert property ($rose(prog_busy) |=> prog_busy[*8])
    else $error("program cycle too short");
  // Tick phase may shorten the cycle by at most one tick
  a_prog_max: assert property (prog_busy |-> busy_r <= MAXC)
    else $error("program cycle too long");
  a_prog_min: assert property ($fell(prog_busy) |-> busy_r >= MAXC - 40)
    else $error("program cycle ended early");
  a_drive_sclow: assert property ($changed(sda_oe_n)
    |-> !scl_i && !$past(scl_i, 3))
    else $error("data line changed while clock high");
  a_idle_after: assert property ($fell(prog_busy) |-> sda_oe_n[*8])
    else $error("drive right after programming");
  c_prog: cover property ($rose(prog_busy));
  c_ack: cover property ($fell(sda_oe_n));
  c_done: cover property ($fell(prog_busy));
endmodule : sep_core_props

bind sep_core sep_core_props #(.PROG_US(PROG_US)) sep_core_props_i (
  .core_clk(core_clk),
  .rst(rst),
  .scl_i(scl_i),
  .sda_i(sda_i),
  .sda_o(sda_o),
  .sda_oe_n(sda_oe_n),
  .write_guard_input(write_guard_input),
  .chip_select_straps(chip_select_straps),
  .prog_busy(prog_busy)
);

// *** sep_master.sv ***
/* Two-wire bus master model: start, stop, byte write and read.
   Assumes the data line is resolved with a pull-up outside. */
`timescale 1ns/1ps
module sep_master #(
  parameter int H = 12
) (
  input wire logic core_clk,
  input wire logic sda,
  output logic scl,
  output logic sda_m
);
  // Clock stands high and data is released between frames
  initial
  begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  task automatic hw();
    repeat (H) @(negedge core_clk);
  endtask : hw
  // Data only moves while the clock is low
  task automatic bit_x(input logic b, output logic r);
    hw();
    sda_m = b;
    hw();
    scl = 1'b1;
    hw();
    r = sda;
    scl = 1'b0;
  endtask : bit_x
  task automatic start();
    hw();
    sda_m = 1'b1;
    hw();
    scl = 1'b1;
    hw();
    sda_m = 1'b0;
    hw();
    scl = 1'b0;
  endtask : start
  task automatic stop();
    hw();
    sda_m = 1'b0;
    hw();
    scl = 1'b1;
    hw();
    sda_m = 1'b1;
    hw();
  endtask : stop
  task automatic wr(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_x(d[i], r);
    bit_x(1'b1, r);
    ack = !r;
  endtask : wr
  task automatic rd(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_x(1'b1, d[i]);
    bit_x(!mack, r);
  endtask : rd
endmodule : sep_master

// *** serial_eeprom_read_write_ops_tb.sv ***
/* Self-checking bench of the EEPROM engine against a byte model.
   Assumes AW of 8 and a program time shortened to 3 ticks. */
`timescale 1ns/1ps
module serial_eeprom_read_write_ops_tb;
  localparam logic [3:0] TID = 4'h9; // Arbitrary identifier
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic guard = 1'b0;
  logic [2:0] straps = 3'h0;
  logic scl, sda_m, sda, sda_o, sda_oe_n, prog_busy, ack;
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;
  int mem[256];
  int ptr = 0;
  always #12.5 core_clk = ~core_clk;
  // Wired AND of both open-drain drivers
  assign sda = sda_m & (sda_oe_n | sda_o);
  sep_core #(.AW(8), .PROG_US(3), .TYPE_ID(TID)) sep_core_i (
    .core_clk(core_clk),
    .rst(rst),
    .scl_i(scl),
    .sda_i(sda),
    .sda_o(sda_o),
    .sda_oe_n(sda_oe_n),
    .write_guard_input(guard),
    .chip_select_straps(straps),
    .prog_busy(prog_busy)
  );
  sep_master sep_master_i (
    .core_clk(core_clk),
    .sda(sda),
    .scl(scl),
    .sda_m(sda_m)
  );
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic close_out();
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : close_out
  task automatic sel(input logic rw, input logic exp);
    logic a;
    sep_master_i.start();
    sep_master_i.wr({TID, straps, rw}, a);
    chk({7'h0, a}, {7'h0, exp});
  endtask : sel
  task automatic wbyte(input logic [7:0] d, input logic exp);
    logic a;
    sep_master_i.wr(d, a);
    chk({7'h0, a}, {7'h0, exp});
  endtask : wbyte
  // Reads n bytes, acknowledging all but the last
  task automatic rseq(input int n);
    logic [7:0] d;
    for (int i = 0; i < n; i++)
    begin
      sep_master_i.rd(i < n - 1, d);
      chk(d, 8'(mem[ptr]));
      ptr = (ptr + 1) % 256;
    end
    sep_master_i.stop();
  endtask : rseq
  // Poll with select codes until the device answers again
  task automatic poll();
    logic a;
    int k;
    k = 0;
    a = 1'b0;
    while (!a && k < 50)
    begin
      sep_master_i.start();
      sep_master_i.wr({TID, straps, 1'b0}, a);
      k++;
    end
    chk({7'h0, a}, 8'h1);
    chk(8'(k > 1), 8'h1);
    sep_master_i.stop();
  endtask : poll
  task automatic wpage(input int a, input int n, input logic g);
    logic [7:0] d;
    guard = g;
    sel(1'b0, 1'b1);
    wbyte(8'(a), 1'b1);
    for (int i = 0; i < n; i++)
    begin
      d = 8'($urandom);
      wbyte(d, !g);
      if (!g)
        mem[(a & 240) | ((a + i) & 15)] = d;
    end
    sep_master_i.stop();
    if (!g)
      ptr = (((a & 240) | ((a + n - 1) & 15)) + 1) % 256;
    repeat (20) @(negedge core_clk);
    chk({7'h0, prog_busy}, {7'h0, !g});
    if (!g)
      poll();
  endtask : wpage
  task automatic rrand(input int a, input int n);
    sel(1'b0, 1'b1);
    wbyte(8'(a), 1'b1);
    ptr = a;
    sel(1'b1, 1'b1);
    rseq(n);
  endtask : rrand
  initial
  begin
    void'($urandom(86578));
    straps = 3'($urandom);
    repeat (16) @(negedge core_clk);
    rst = 1'b0;
    repeat (8) @(negedge core_clk);
    for (int i = 0; i < 256; i++)
      mem[i] = 255;
    sel(1'b1, 1'b1);
    rseq(3);
    $display("test erased read done");
    wpage(8'h12, 1, 1'b0);
    wpage(8'h1e, 4, 1'b0);
    sel(1'b1, 1'b1);
    rseq(1);
    rrand(8'h10, 16);
    $display("test page wrap done");
    wpage(8'hfe, 2, 1'b0);
    rrand(8'hfe, 4);
    $display("test counter wrap done");
    wpage(8'h40, 3, 1'b1);
    rrand(8'h3f, 3);
    guard = 1'b0;
    $display("test guard done");
    sep_master_i.start();
    sep_master_i.wr({TID, ~straps, 1'b1}, ack);
    chk({7'h0, ack}, 8'h0);
    sep_master_i.start();
    sep_master_i.wr({~TID, straps, 1'b1}, ack);
    chk({7'h0, ack}, 8'h0);
    sep_master_i.stop();
    sel(1'b0, 1'b1);
    wbyte(8'h50, 1'b1);
    sep_master_i.stop();
    repeat (20) @(negedge core_clk);
    chk({7'h0, prog_busy}, 8'h0);
    // Acknowledged data byte, then a Stop in the third slot of the next byte
    sel(1'b0, 1'b1);
    wbyte(8'h50, 1'b1);
    wbyte(8'h5a, 1'b1);
    sep_master_i.bit_x(1'b0, ack);
    sep_master_i.bit_x(1'b1, ack);
    sep_master_i.stop();
    repeat (20) @(negedge core_clk);
    chk({7'h0, prog_busy}, 8'h0);
    rrand(8'h50, 1);
    $display("test foreign and early stop done");
    for (int k = 0; k < 4; k++)
    begin
      ptr = int'($urandom % 256);
      wpage(ptr, 1, 1'b0);
      rrand((ptr + 255) % 256, 1);
    end
    $display("test random bytes done");
    close_out();
  end
  // Hang guard well above the expected run length
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      error_cnt++;
      close_out();
    end
  end
endmodule : serial_eeprom_read_write_ops_tb
